//--- verilog/ssd_pkg.sv
// shared constants and types of the safety sensor diagnostic status block
package ssd_pkg;
  // response byte bit positions
  localparam int RESP_OUT_EN  = 0;
  localparam int RESP_ACT     = 1;
  localparam int RESP_IN_LIVE = 4;
  localparam int RESP_LIMIT   = 5;
  localparam int RESP_WARN    = 6;
  localparam int RESP_ERR     = 7;
  // warning and error detail byte bit positions
  localparam int DET_OUT_A     = 0;
  localparam int DET_OUT_B     = 1;
  localparam int DET_CROSS     = 2;
  localparam int DET_TEMP      = 3;
  localparam int DET_WRONG_ACT = 4;
  localparam int DET_INTERNAL  = 5;
  localparam int DET_COMM      = 6;
  // request byte bit positions
  localparam int REQ_ERR_RESET = 7;
  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // timing
  localparam longint CLK_HZ           = 100_000_000;
  localparam int     FLASH_HZ         = 1;
  localparam int     HALVES_PER_SEC   = 2;
  localparam int     SEC_PER_MIN      = 60;
  localparam int     WARN_TIME_MIN    = 30;
  localparam int     PROTECT_TIME_MIN = 10;
  localparam int     HALF_CYCLES_DEF  = int'(CLK_HZ / (HALVES_PER_SEC * FLASH_HZ));
  localparam int     WARN_HALVES_DEF  = WARN_TIME_MIN * SEC_PER_MIN * HALVES_PER_SEC;
  localparam int     PROT_HALVES_DEF  = PROTECT_TIME_MIN * SEC_PER_MIN * HALVES_PER_SEC;
  localparam int     TIMER_W          = 16;
  // chain limit, synchroniser depth and synchronised pin count
  localparam int CHAIN_MAX_DEVICES = 31;
  localparam int SYNC_STAGES       = 2;
  localparam int PIN_COUNT         = 5;
  // red flash codes (number of pulses); steady means continuous red
  localparam logic [2:0] CODE_NONE   = 3'h0;
  localparam logic [2:0] CODE_OUT_A  = 3'h1;
  localparam logic [2:0] CODE_OUT_B  = 3'h2;
  localparam logic [2:0] CODE_CROSS  = 3'h3;
  localparam logic [2:0] CODE_TEMP   = 3'h4;
  localparam logic [2:0] CODE_WRONG  = 3'h5;
  localparam logic [2:0] CODE_STEADY = 3'h7;
  localparam logic [3:0] FLASH_PAUSE = 4'h4;
  // indication modes, highest priority first
  typedef enum logic [2:0] {
    SSD_ERROR    = 3'b000,
    SSD_TEACH    = 3'b001,
    SSD_PROTECT  = 3'b010,
    SSD_WARN     = 3'b011,
    SSD_INFAULT  = 3'b100,
    SSD_LIMIT    = 3'b101,
    SSD_ACTUATED = 3'b110,
    SSD_IDLE     = 3'b111
  } ssd_mode_t;
endpackage

//--- verilog/ssd_flash_if.sv
// flash timing signals between the status logic and the flash generator
`timescale 1ns/1ps
`default_nettype none
interface ssd_flash_if;
  logic [2:0] flashCode;
  logic       halfTick;
  logic       slowFlash;
  logic       codeFlash;
  modport gen (input flashCode, output halfTick, output slowFlash, output codeFlash);
  modport user (output flashCode, input halfTick, input slowFlash, input codeFlash);
endinterface
`default_nettype wire

//--- verilog/ssd_flash_gen.sv
// half-second tick, 1 Hz flash and red pulse-count flash generator
`timescale 1ns/1ps
`default_nettype none
module ssd_flash_gen
  import ssd_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_CYCLES_DEF
) (
  input  wire logic  mclk,
  input  wire logic  reset,
  ssd_flash_if.gen   fl
);
  localparam int DIV_W = $clog2(HALF_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYCLES - 1);

  logic [DIV_W-1:0] div_q;
  logic [3:0]       slot_q;
  logic [2:0]       lastCode_q;
  logic [3:0]       slotLast;

  assign slotLast = {fl.flashCode, 1'b0} + FLASH_PAUSE - 4'h1;

  // half-second enable pulse
  always_ff @(posedge mclk) begin
    if (reset || div_q == DIV_LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fl.halfTick <= 1'b0;
    end else begin
      fl.halfTick <= (div_q == DIV_LAST);
    end
  end

  // 1 Hz square wave
  always_ff @(posedge mclk) begin
    if (reset) begin
      fl.slowFlash <= 1'b0;
    end else if (fl.halfTick) begin
      fl.slowFlash <= ~fl.slowFlash;
    end
  end

  // pulse slots: on/off pairs per counted pulse, then a dark pause
  always_ff @(posedge mclk) begin
    if (reset) begin
      slot_q     <= '0;
      lastCode_q <= CODE_NONE;
    end else begin
      lastCode_q <= fl.flashCode;
      if (fl.flashCode != lastCode_q) begin
        slot_q <= '0;
      end else if (fl.halfTick) begin
        slot_q <= (slot_q >= slotLast) ? 4'h0 : slot_q + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fl.codeFlash <= 1'b0;
    end else if (fl.flashCode == CODE_STEADY) begin
      fl.codeFlash <= 1'b1;
    end else begin
      fl.codeFlash <= (slot_q < {fl.flashCode, 1'b0}) && !slot_q[0];
    end
  end
endmodule
`default_nettype wire

//--- verilog/ssd_status.sv
// diagnostic status logic: lamps, diagnostic output, safety outputs, serial bytes
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1 - idle, inputs live: green only, outputs off
// RL2 - actuated: steady yellow, diag high, outputs on
// RL3 - limit zone: yellow and diag flash, outputs on
// RL4 - warning: red flash, diag low, off after 30min
// RL5 - error: red code flash, everything low
// RL6 - teach: red steady, yellow flash, all low
// RL7 - after reteach: 10 minute pause, green flashes
// RL8 - input missing, no actuator: green flash, low
// RL9 - input missing, actuated: green flash, yellow, diag
// RL10 - serial diag passes through chain, max 31
// RL11 - continuously supply bytes, accept request byte
// RL12 - comm error holds safety outputs unchanged
// RL13 - response bits 0,1,4: enabled, actuated, inputs
// RL14 - response bits 5,6,7: limit, warning, error
// RL15 - error clears: cause gone plus guard/reset fall
// RL16 - output faults latched until next output release
// RL17 - detail byte bits 0-3 output, cross, temperature
// RL18 - error bits 4,5 actuator/internal; warning bit 5
// RL19 - warning bit 6 flags communication failure
// RL20 - red pulse count identifies error cause
// RL21 - warning clears itself when cause disappears
// RL22 - priority error, teach, protect, warning, input, normal
module ssd_status
  import ssd_pkg::*;
#(
  parameter int HALF_CYCLES   = HALF_CYCLES_DEF,
  parameter int WARN_HALVES   = WARN_HALVES_DEF,
  parameter int PROT_HALVES   = PROT_HALVES_DEF
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       safetyInA,
  input  wire logic       safetyInB,
  input  wire logic       actuatorDetect,
  input  wire logic       actuatorLimit,
  input  wire logic       teachMode,
  input  wire logic       teachDone,
  input  wire logic       outFaultA,
  input  wire logic       outFaultB,
  input  wire logic       crossWire,
  input  wire logic       overTemp,
  input  wire logic       wrongActuator,
  input  wire logic       internalFault,
  input  wire logic       commError,
  input  wire logic [7:0] requestByte,
  input  wire logic       requestStrobe,
  input  wire logic       serialDiagIn,
  input  wire logic       ownSlot,
  input  wire logic       ownTxBit,
  output logic            ledGreen,
  output logic            ledRed,
  output logic            ledYellow,
  output logic            diagOut,
  output logic            safetyOutA,
  output logic            safetyOutB,
  output logic            serialDiagOut,
  output logic [7:0]      hostRequest,
  output logic [7:0]      sensorResponse,
  output logic [7:0]      warningDetail,
  output logic [7:0]      errorDetail
);
  localparam logic [TIMER_W-1:0] WARN_LAST = TIMER_W'(WARN_HALVES);
  localparam logic [TIMER_W-1:0] PROT_LAST = TIMER_W'(PROT_HALVES);

  ssd_flash_if fl ();

  ssd_flash_gen #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_flash (
    .mclk  (mclk),
    .reset (reset),
    .fl    (fl)
  );

  logic [PIN_COUNT-1:0] pinMeta_q;
  logic [PIN_COUNT-1:0] pinSync_q;
  logic                 inA;
  logic                 inB;
  logic                 actuated;
  logic                 inLimit;
  logic                 diagInSync;
  logic                 inputsLive;
  logic [2:0]           outFault_q;
  logic [2:0]           liveOutFault;
  logic                 warnActive;
  logic [TIMER_W-1:0]   warnCnt_q;
  logic                 warnExpired;
  logic [TIMER_W-1:0]   protCnt_q;
  logic                 protecting;
  logic                 error_q;
  logic                 errorCause;
  logic                 causeLive;
  logic                 resetFall;
  logic                 enable_d;
  logic                 enable_q;
  logic                 outRelease;
  ssd_mode_t            mode_d;
  ssd_mode_t            mode_q;
  logic [2:0]           code_d;

  // two-flop synchronisers for pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= {serialDiagIn, actuatorLimit, actuatorDetect, safetyInB, safetyInA};
      pinSync_q <= pinMeta_q;
    end
  end

  assign inA        = pinSync_q[0];
  assign inB        = pinSync_q[1];
  assign actuated   = pinSync_q[2];
  assign inLimit    = pinSync_q[3] & actuated;
  assign diagInSync = pinSync_q[4];
  assign inputsLive = inA & inB;

  // output fault latches; clear only on the next release of the outputs
  assign liveOutFault = {crossWire, outFaultB, outFaultA};
  assign outRelease   = enable_d & ~enable_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      outFault_q <= '0;
    end else begin
      outFault_q <= liveOutFault | (outRelease ? 3'h0 : outFault_q); // RL16
    end
  end

  // warning follows its causes; latched output faults count as causes
  assign warnActive = (|outFault_q) | overTemp | internalFault; // RL21

  always_ff @(posedge mclk) begin
    if (reset || !warnActive || error_q) begin
      warnCnt_q <= '0;
    end else if (fl.halfTick && !warnExpired) begin
      warnCnt_q <= warnCnt_q + 1'b1; // RL4
    end
  end

  assign warnExpired = (warnCnt_q == WARN_LAST); // RL4

  // protection pause after a new actuator is taught
  always_ff @(posedge mclk) begin
    if (reset) begin
      protCnt_q <= '0;
    end else if (teachDone) begin
      protCnt_q <= PROT_LAST; // RL7
    end else if (fl.halfTick && protCnt_q != '0) begin
      protCnt_q <= protCnt_q - 1'b1;
    end
  end

  assign protecting = (protCnt_q != '0);

  // request byte taken on its strobe; bit 7 falling edge resets errors
  always_ff @(posedge mclk) begin
    if (reset) begin
      hostRequest <= BYTE_RESET;
    end else if (requestStrobe) begin
      hostRequest <= requestByte; // RL11
    end
  end

  assign resetFall = requestStrobe & hostRequest[REQ_ERR_RESET] & ~requestByte[REQ_ERR_RESET];

  // error latch: set wins over clear
  assign errorCause = internalFault | wrongActuator | warnExpired;
  assign causeLive  = internalFault | wrongActuator | (|liveOutFault) | overTemp;

  always_ff @(posedge mclk) begin
    if (reset) begin
      error_q <= 1'b0;
    end else if (errorCause) begin
      error_q <= 1'b1;
    end else if (!causeLive && (!actuated || resetFall)) begin
      error_q <= 1'b0; // RL15
    end
  end

  // safety output enable
  always_comb begin
    enable_d = actuated & inputsLive & ~error_q & ~teachMode & ~teachDone & ~protecting; // RL7
    if (commError) begin
      enable_d = enable_q; // RL12
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
    end
  end

  // indication mode by priority
  always_comb begin
    if (error_q) begin
      mode_d = SSD_ERROR; // RL22
    end else if (teachMode) begin
      mode_d = SSD_TEACH;
    end else if (protecting || teachDone) begin
      mode_d = SSD_PROTECT;
    end else if (warnActive) begin
      mode_d = SSD_WARN;
    end else if (!inputsLive) begin
      mode_d = SSD_INFAULT;
    end else if (inLimit) begin
      mode_d = SSD_LIMIT;
    end else if (actuated) begin
      mode_d = SSD_ACTUATED;
    end else begin
      mode_d = SSD_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_q <= SSD_IDLE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // red pulse count naming the cause
  always_comb begin
    if (internalFault) begin
      code_d = CODE_STEADY;
    end else if (outFault_q[0]) begin
      code_d = CODE_OUT_A; // RL20
    end else if (outFault_q[1]) begin
      code_d = CODE_OUT_B;
    end else if (outFault_q[2]) begin
      code_d = CODE_CROSS;
    end else if (overTemp) begin
      code_d = CODE_TEMP;
    end else if (wrongActuator) begin
      code_d = CODE_WRONG;
    end else begin
      code_d = CODE_NONE;
    end
  end

  assign fl.flashCode = (mode_q == SSD_ERROR || mode_q == SSD_WARN) ? code_d : CODE_NONE;

  // lamps and diagnostic output
  always_ff @(posedge mclk) begin
    if (reset) begin
      ledGreen  <= 1'b0;
      ledRed    <= 1'b0;
      ledYellow <= 1'b0;
      diagOut   <= 1'b0;
    end else begin
      unique case (mode_q)
        SSD_ERROR: begin
          ledGreen  <= 1'b0;
          ledRed    <= fl.codeFlash; // RL5
          ledYellow <= 1'b0;
          diagOut   <= 1'b0;
        end
        SSD_TEACH: begin
          ledGreen  <= 1'b0;
          ledRed    <= 1'b1; // RL6
          ledYellow <= fl.slowFlash;
          diagOut   <= 1'b0;
        end
        SSD_PROTECT: begin
          ledGreen  <= fl.slowFlash; // RL7
          ledRed    <= 1'b0;
          ledYellow <= 1'b0;
          diagOut   <= 1'b0;
        end
        SSD_WARN: begin
          ledGreen  <= 1'b0;
          ledRed    <= fl.codeFlash; // RL4
          ledYellow <= 1'b0;
          diagOut   <= 1'b0;
        end
        SSD_INFAULT: begin
          ledGreen  <= fl.slowFlash; // RL8
          ledRed    <= 1'b0;
          ledYellow <= actuated; // RL9
          diagOut   <= actuated;
        end
        SSD_LIMIT: begin
          ledGreen  <= 1'b0;
          ledRed    <= 1'b0;
          ledYellow <= fl.slowFlash; // RL3
          diagOut   <= fl.slowFlash;
        end
        SSD_ACTUATED: begin
          ledGreen  <= 1'b0;
          ledRed    <= 1'b0;
          ledYellow <= 1'b1; // RL2
          diagOut   <= 1'b1;
        end
        SSD_IDLE: begin
          ledGreen  <= 1'b1; // RL1
          ledRed    <= 1'b0;
          ledYellow <= 1'b0;
          diagOut   <= 1'b0;
        end
      endcase
    end
  end

  // safety outputs follow the registered enable
  always_ff @(posedge mclk) begin
    if (reset) begin
      safetyOutA <= 1'b0;
      safetyOutB <= 1'b0;
    end else begin
      safetyOutA <= enable_q; // RL1
      safetyOutB <= enable_q;
    end
  end

  // response byte, refreshed every cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      sensorResponse <= BYTE_RESET;
    end else begin
      sensorResponse               <= BYTE_RESET; // RL11
      sensorResponse[RESP_OUT_EN]  <= enable_q; // RL13
      sensorResponse[RESP_ACT]     <= actuated;
      sensorResponse[RESP_IN_LIVE] <= inputsLive;
      sensorResponse[RESP_LIMIT]   <= inLimit; // RL14
      sensorResponse[RESP_WARN]    <= warnActive & ~error_q;
      sensorResponse[RESP_ERR]     <= error_q;
    end
  end

  // warning detail byte, readable while a warning is flagged
  always_ff @(posedge mclk) begin
    if (reset) begin
      warningDetail <= BYTE_RESET;
    end else begin
      warningDetail               <= BYTE_RESET;
      warningDetail[DET_COMM]     <= commError; // RL19
      if (warnActive && !error_q) begin
        warningDetail[DET_OUT_A]    <= outFault_q[0]; // RL17
        warningDetail[DET_OUT_B]    <= outFault_q[1];
        warningDetail[DET_CROSS]    <= outFault_q[2];
        warningDetail[DET_TEMP]     <= overTemp;
        warningDetail[DET_INTERNAL] <= internalFault; // RL18
      end
    end
  end

  // error detail byte, readable while an error is flagged
  always_ff @(posedge mclk) begin
    if (reset) begin
      errorDetail <= BYTE_RESET;
    end else begin
      errorDetail <= BYTE_RESET;
      if (error_q) begin
        errorDetail[DET_OUT_A]     <= outFault_q[0]; // RL17
        errorDetail[DET_OUT_B]     <= outFault_q[1];
        errorDetail[DET_CROSS]     <= outFault_q[2];
        errorDetail[DET_TEMP]      <= overTemp;
        errorDetail[DET_WRONG_ACT] <= wrongActuator; // RL18
        errorDetail[DET_INTERNAL]  <= internalFault;
      end
    end
  end

  // chain pass-through: own slot drives the line, otherwise repeat upstream
  always_ff @(posedge mclk) begin
    if (reset) begin
      serialDiagOut <= 1'b0;
    end else begin
      serialDiagOut <= ownSlot ? ownTxBit : diagInSync; // RL10
    end
  end
endmodule
`default_nettype wire

//--- sim/ssd_status_asserts.sv
// concurrent checks on the ports of the diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module ssd_status_asserts
  import ssd_pkg::*;
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       safetyInA,
  input wire logic       teachMode,
  input wire logic       teachDone,
  input wire logic       outFaultA,
  input wire logic       outFaultB,
  input wire logic       crossWire,
  input wire logic       overTemp,
  input wire logic       wrongActuator,
  input wire logic       internalFault,
  input wire logic       commError,
  input wire logic [7:0] requestByte,
  input wire logic       requestStrobe,
  input wire logic       serialDiagIn,
  input wire logic       ownSlot,
  input wire logic       ownTxBit,
  input wire logic       ledRed,
  input wire logic       diagOut,
  input wire logic       safetyOutA,
  input wire logic       safetyOutB,
  input wire logic       serialDiagOut,
  input wire logic [7:0] hostRequest,
  input wire logic [7:0] sensorResponse,
  input wire logic [7:0] warningDetail
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // no live cause that would refuse an error clear
  wire logic noCause = !(outFaultA || outFaultB || crossWire || overTemp ||
                         wrongActuator || internalFault);

  AST_OUT_PAIR: assert property (safetyOutA == safetyOutB)
    else $error("safety outputs differ");
  AST_RESP_EN: assert property (sensorResponse[RESP_OUT_EN] == safetyOutA)
    else $error("enable bit disagrees with safety outputs");
  AST_ERR_LOW: assert property ((sensorResponse[RESP_ERR] && !commError) [*3]
    |-> !safetyOutA && !diagOut) else $error("outputs high during error");
  AST_TEACH: assert property ((teachMode && !commError && !sensorResponse[RESP_ERR]) [*4]
    |-> ledRed && !diagOut && !safetyOutA) else $error("teach indication wrong");
  AST_REQ_TAKE: assert property (requestStrobe |=> hostRequest == $past(requestByte))
    else $error("request byte not taken");
  AST_COMM_HOLD: assert property (commError [*4] |-> $stable(safetyOutA))
    else $error("safety outputs moved during comm error");
  AST_COMM_FLAG: assert property ($rose(commError) |-> ##[1:3] warningDetail[DET_COMM])
    else $error("comm failure bit not raised");
  AST_ERR_CLEAR: assert property (requestStrobe && !requestByte[REQ_ERR_RESET] &&
    hostRequest[REQ_ERR_RESET] && noCause |-> ##2 !sensorResponse[RESP_ERR])
    else $error("error not cleared by request fall");
  AST_SLOT_TX: assert property (ownSlot |=> serialDiagOut == $past(ownTxBit))
    else $error("own slot bit not sent");
  AST_CHAIN_PASS: assert property ((!ownSlot && $stable(serialDiagIn)) [*5]
    |-> serialDiagOut == serialDiagIn) else $error("chain bit not passed on");
  AST_IN_LIVE: assert property ($fell(safetyInA) |-> ##[1:6] !sensorResponse[RESP_IN_LIVE])
    else $error("input live bit stuck");
  AST_PROT_LOW: assert property (teachDone && !commError |-> ##2 !safetyOutA [*3])
    else $error("safety outputs on after reteach");

  COV_CLEAR: cover property (requestStrobe && hostRequest[7] && !requestByte[7]);
  COV_TEACH: cover property (teachMode && ledRed);
  COV_HOLD: cover property (commError && safetyOutA);
endmodule

bind ssd_status ssd_status_asserts u_chk (.mclk, .reset, .safetyInA, .teachMode, .outFaultA,
  .outFaultB, .crossWire, .overTemp, .wrongActuator, .internalFault, .commError, .requestByte,
  .requestStrobe, .serialDiagIn, .ownSlot, .ownTxBit, .ledRed, .diagOut, .safetyOutA,
  .safetyOutB, .serialDiagOut, .hostRequest, .sensorResponse, .warningDetail, .teachDone);
`default_nettype wire

//--- sim/ssd_chain_model.sv
// upstream chain neighbour and slot framer driving the serial diagnostic pins
`timescale 1ns/1ps
`default_nettype none
module ssd_chain_model (
  input  wire logic mclk,
  input  wire logic reset,
  output logic      serialDiagIn,
  output logic      ownSlot,
  output logic      ownTxBit
);
  logic [4:0] tick;
  logic [7:0] pat;
  initial begin
    tick = 5'h00;
    pat = 8'h5a;
    serialDiagIn = 1'b1;
    ownSlot = 1'b0;
    ownTxBit = 1'b0;
  end
  // upstream bits held eight cycles, own slot four cycles of every 24
  always @(posedge mclk) begin
    tick <= (reset || tick == 5'h17) ? 5'h00 : tick + 5'h01;
    ownSlot <= (tick >= 5'h14);
    ownTxBit <= ~ownTxBit;
    if (tick[2:0] == 3'h0) begin
      pat <= {pat[6:0], pat[7] ^ pat[5]};
      serialDiagIn <= pat[0];
    end
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
// self-checking bench of the diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssd_pkg::*;
  localparam logic [1:0] F0 = 2'h0, F1 = 2'h1, FL = 2'h2, DC = 2'h3;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       safetyInA, safetyInB, actuatorDetect, actuatorLimit, teachMode, teachDone;
  logic       commError, requestStrobe, serialDiagIn, ownSlot, ownTxBit;
  logic [5:0] causes;
  logic [7:0] requestByte;
  logic       ledGreen, ledRed, ledYellow, diagOut, safetyOutA, safetyOutB, serialDiagOut;
  logic [7:0] hostRequest, sensorResponse, warningDetail, errorDetail;
  int         errors = 0;
  int         n_compared = 0;
  int         idx [5] = '{0, 1, 2, 4, 5};
  logic [7:0] npul [5] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h00};

  ssd_status #(.HALF_CYCLES(4), .WARN_HALVES(6), .PROT_HALVES(4)) dut (
    .mclk, .reset, .safetyInA, .safetyInB, .actuatorDetect, .actuatorLimit, .teachMode,
    .teachDone, .outFaultA(causes[0]), .outFaultB(causes[1]), .crossWire(causes[2]),
    .overTemp(causes[3]), .wrongActuator(causes[4]), .internalFault(causes[5]),
    .commError, .requestByte, .requestStrobe, .serialDiagIn, .ownSlot, .ownTxBit,
    .ledGreen, .ledRed, .ledYellow, .diagOut, .safetyOutA, .safetyOutB, .serialDiagOut,
    .hostRequest, .sensorResponse, .warningDetail, .errorDetail);
  ssd_chain_model gw (.mclk, .reset, .serialDiagIn, .ownSlot, .ownTxBit);

  always #5 mclk = ~mclk;

  task automatic stop_test();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic write_req(input logic [7:0] b);
    @(posedge mclk);
    requestByte <= b;
    requestStrobe <= 1'b1;
    @(posedge mclk);
    requestStrobe <= 1'b0;
  endtask

  // lamp and output codes over a window: off, on, flashing, or ignored
  task automatic look(input int s, input int n, input logic [11:0] exp);
    logic [5:0]  hi, lo, v;
    logic [11:0] got;
    hi = '0;
    lo = '1;
    step(s);
    repeat (n) begin
      step(1);
      v = {ledGreen, ledRed, ledYellow, diagOut, safetyOutA, safetyOutB};
      hi = hi | v;
      lo = lo & v;
    end
    for (int i = 0; i < 6; i++) begin
      got[2*i+:2] = (exp[2*i+:2] == DC) ? DC : lo[i] ? F1 : hi[i] ? FL : F0;
    end
    chk(got, exp);
  endtask

  // counts red pulses in one burst after a dark gap
  task automatic pulses(input logic [7:0] n);
    int         dark;
    logic [7:0] cnt;
    logic       prev;
    dark = 0;
    cnt = 8'h00;
    prev = 1'b0;
    for (int i = 0; i < 200 && dark < 12; i++) begin
      step(1);
      dark = (ledRed === 1'b0) ? dark + 1 : 0;
    end
    for (int i = 0; i < 200 && ledRed !== 1'b1; i++) step(1);
    repeat (8 * n + 10) begin
      cnt = cnt + {7'h00, ledRed === 1'b1 && !prev};
      prev = ledRed;
      step(1);
    end
    chk(cnt, n);
  endtask

  // whole run is near 1200 cycles, so 20000 means a hang
  initial begin
    #200000;
    errors++;
    stop_test();
  end

  initial begin
    {safetyInA, safetyInB} = 2'h3;
    {actuatorDetect, actuatorLimit, teachMode, teachDone, commError, requestStrobe} = '0;
    causes = '0;
    requestByte = 8'h00;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    look(10, 16, {F1, F0, F0, F0, F0, F0});
    chk(sensorResponse, 8'h10);
    @(posedge mclk) actuatorDetect <= 1'b1;
    look(10, 16, {F0, F0, F1, F1, F1, F1});
    chk(sensorResponse, 8'h13);
    @(posedge mclk) actuatorLimit <= 1'b1;
    look(8, 16, {F0, F0, FL, FL, F1, F1});
    chk(sensorResponse, 8'h33);
    @(posedge mclk) actuatorLimit <= 1'b0;
    @(posedge mclk) commError <= 1'b1;
    step(6);
    @(posedge mclk) actuatorDetect <= 1'b0;
    look(8, 16, {DC, DC, DC, DC, F1, F1});
    chk(warningDetail[DET_COMM], 1'b1);
    @(posedge mclk) commError <= 1'b0;
    look(8, 16, {F1, F0, F0, F0, F0, F0});
    @(posedge mclk) safetyInA <= 1'b0;
    look(10, 16, {FL, F0, F0, F0, F0, F0});
    chk(sensorResponse, 8'h00);
    @(posedge mclk) actuatorDetect <= 1'b1;
    look(10, 16, {FL, F0, F1, F1, F0, F0});
    chk(sensorResponse, 8'h02);
    @(posedge mclk) safetyInA <= 1'b1;
    step(10);
    @(posedge mclk) causes[3] <= 1'b1;
    step(6);
    @(posedge mclk) causes[3] <= 1'b0;
    look(6, 8, {F0, F0, F1, F1, F1, F1});
    chk(sensorResponse, 8'h13);
    @(posedge mclk) causes[3] <= 1'b1;
    look(4, 8, {F0, DC, F0, F0, F1, F1});
    chk(sensorResponse, 8'h53);
    chk(warningDetail[DET_TEMP], 1'b1);
    step(40);
    look(0, 8, {F0, DC, F0, F0, F0, F0});
    chk(sensorResponse[RESP_ERR], 1'b1);
    chk(errorDetail[DET_TEMP], 1'b1);
    pulses(8'h04);
    @(posedge mclk) causes[3] <= 1'b0;
    step(8);
    chk(sensorResponse[RESP_ERR], 1'b1);
    write_req(8'h80);
    write_req(8'h00);
    step(1);
    chk(hostRequest, 8'h00);
    step(2);
    chk(sensorResponse[RESP_ERR], 1'b0);
    look(6, 8, {F0, F0, F1, F1, F1, F1});
    foreach (idx[k]) begin
      @(posedge mclk) causes[idx[k]] <= 1'b1;
      step(40);
      look(0, 8, {F0, DC, F0, F0, F0, F0});
      chk(errorDetail[idx[k]], 1'b1);
      if (npul[k] == 8'h00) look(0, 16, {F0, F1, F0, F0, F0, F0});
      else pulses(npul[k]);
      @(posedge mclk) causes[idx[k]] <= 1'b0;
      step(6);
      if (k < 3) chk(errorDetail[idx[k]], 1'b1);
      chk(sensorResponse[RESP_ERR], 1'b1);
      @(posedge mclk) actuatorDetect <= 1'b0;
      step(8);
      chk(sensorResponse[RESP_ERR], 1'b0);
      @(posedge mclk) actuatorDetect <= 1'b1;
      look(8, 8, {F0, F0, F1, F1, F1, F1});
      chk(errorDetail, 8'h00);
    end
    @(posedge mclk) teachMode <= 1'b1;
    look(6, 16, {F0, F1, FL, F0, F0, F0});
    @(posedge mclk) begin
      teachMode <= 1'b0;
      teachDone <= 1'b1;
    end
    @(posedge mclk) teachDone <= 1'b0;
    look(0, 8, {FL, F0, DC, F0, F0, F0});
    step(24);
    look(0, 8, {F0, F0, F1, F1, F1, F1});
    stop_test();
  end
endmodule
`default_nettype wire
